// ---- common/icm_pkg.sv ----
// shared constants, types and saturating helpers for the interpolation path
`default_nettype none
package icm_pkg;

	// register byte offsets
	localparam logic [7:0] ICM_OFF_CTRL   = 8'h00;
	localparam logic [7:0] ICM_OFF_MODE   = 8'h04;
	localparam logic [7:0] ICM_OFF_TUNE   = 8'h08;
	localparam logic [7:0] ICM_OFF_UPD    = 8'h0c;
	localparam logic [7:0] ICM_OFF_STAT   = 8'h10;
	localparam logic [7:0] ICM_OFF_ACTIVE = 8'h14;
	localparam logic [7:0] ICM_OFF_PHASE  = 8'h18;

	// control field positions and mode field stride
	localparam int ICM_CTRL_BW_LSB = 0;
	localparam int ICM_CTRL_EN_LSB = 2;
	localparam int ICM_CTRL_PM_BIT = 5;
	localparam int ICM_MODE_STRIDE = 4;

	// values after reset
	localparam logic [31:0] ICM_CTRL_RST = 32'h0000_0002;
	localparam logic [31:0] ICM_MODE_RST = 32'h0000_0000;
	localparam logic [31:0] ICM_TUNE_RST = 32'h0000_0000;

	// bus width codes and last transfer index per i/q pair
	localparam logic [1:0] ICM_BW_NIBBLE = 2'h0;
	localparam logic [1:0] ICM_BW_BYTE   = 2'h1;
	localparam logic [1:0] ICM_BW_WORD   = 2'h2;
	localparam logic [2:0] ICM_LAST_NIBBLE = 3'h7;
	localparam logic [2:0] ICM_LAST_BYTE   = 3'h3;
	localparam logic [2:0] ICM_LAST_WORD   = 3'h1;

	// buffer shape, stage count
	localparam int ICM_FIFO_WIDTH = 32;
	localparam int ICM_FIFO_DEPTH = 4;
	localparam int ICM_STAGES     = 3;

	// sqrt(2)/2 in q15
	localparam logic signed [16:0] ICM_R_COEF = 17'sh05a82;

	// coarse mixing modes
	typedef enum logic [2:0]
	{
		ICM_MIX_NONE,
		ICM_MIX_FS2,
		ICM_MIX_FS4,
		ICM_MIX_FS34,
		ICM_MIX_FS8
	} icm_mix_t;

	// clip a wide value to the signed 16-bit range
	function automatic logic signed [15:0] icm_sat(input logic signed [18:0] v);
		if (v > 19'sd32767)
			return 16'sh7fff;
		else if (v < -19'sd32768)
			return 16'sh8000;
		else
			return v[15:0];
	endfunction

	// negate without wrapping the most negative code
	function automatic logic signed [15:0] icm_neg(input logic signed [15:0] x);
		if (x == 16'sh8000)
			return 16'sh7fff;
		else
			return -x;
	endfunction

	// r times a 17-bit sum, saturated
	function automatic logic signed [15:0] icm_rmul(input logic signed [16:0] s);
		logic signed [33:0] p;
		p = s * ICM_R_COEF;
		return icm_sat(p[33:15]);
	endfunction

	// one step of a mixing sequence, returns {i, q}
	function automatic logic [31:0] icm_mix(input logic signed [15:0] i,
		input logic signed [15:0] q, input logic [2:0] idx, input logic [2:0] md);
		logic signed [15:0] rp;
		logic signed [15:0] rd;
		rp = icm_rmul({i[15], i} + {q[15], q});
		rd = icm_rmul({q[15], q} - {i[15], i});
		case (md)
			ICM_MIX_FS2:
				return idx[0] ? {icm_neg(i), icm_neg(q)} : {i, q};
			ICM_MIX_FS4:
				case (idx[1:0])
					2'h0: return {i, q};
					2'h1: return {q, icm_neg(i)};
					2'h2: return {icm_neg(i), icm_neg(q)};
					default: return {icm_neg(q), i};
				endcase
			ICM_MIX_FS34:
				case (idx[1:0])
					2'h0: return {i, q};
					2'h1: return {icm_neg(q), i};
					2'h2: return {icm_neg(i), icm_neg(q)};
					default: return {q, icm_neg(i)};
				endcase
			ICM_MIX_FS8:
				case (idx)
					3'h0: return {i, q};
					3'h1: return {rp, rd};
					3'h2: return {q, icm_neg(i)};
					3'h3: return {rd, icm_neg(rp)};
					3'h4: return {icm_neg(i), icm_neg(q)};
					3'h5: return {icm_neg(rp), icm_neg(rd)};
					3'h6: return {icm_neg(q), i};
					default: return {icm_neg(rd), rp};
				endcase
			default:
				return {i, q};
		endcase
	endfunction

endpackage
`default_nettype wire

// ---- hw/icm_fifo.sv ----
// small valid/ready fifo for assembled i/q pairs
`timescale 1ns/100ps
`default_nettype none
module icm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// clock, reset, enable
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             ce_in,
	// fill side
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// drain side
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// honest full and empty from the occupancy count
	assign wr_ready_out = (count != (AW+1)'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign rd_data_out  = mem[rd_ptr];
	assign push         = ce_in & wr_valid_in & wr_ready_out;
	assign pop          = ce_in & rd_valid_out & rd_ready_in;

	// storage
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_ptr] <= wr_data_in;
	end

	// pointers and count
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ---- hw/icm_hb_stage.sv ----
// one 2x interpolating stage with built-in coarse mixing
`timescale 1ns/100ps
`default_nettype none
module icm_hb_stage (
	// clock, reset, enable
	input  wire logic               clk_in,
	input  wire logic               arst_n_in,
	input  wire logic               ce_in,
	// configuration
	input  wire logic               enable_in,
	input  wire logic [2:0]         mode_in,
	// input samples
	input  wire logic               in_valid_in,
	output logic                    in_ready_out,
	input  wire logic signed [15:0] in_i_in,
	input  wire logic signed [15:0] in_q_in,
	// output samples at twice the rate
	output logic                    out_valid_out,
	input  wire logic               out_ready_in,
	output logic signed [15:0]      out_i_out,
	output logic signed [15:0]      out_q_out
);
	logic               have;
	logic               ph;
	logic [2:0]         idx;
	logic signed [15:0] a_i;
	logic signed [15:0] a_q;
	logic signed [15:0] b_i;
	logic signed [15:0] b_q;
	logic signed [16:0] sum_i;
	logic signed [16:0] sum_q;
	logic signed [15:0] pre_i;
	logic signed [15:0] pre_q;
	logic [31:0]        mixed;
	logic               load;
	logic               fire;
	logic               last;

	// handshake and phase decode
	assign in_ready_out = ~have;
	assign load  = ce_in & in_valid_in & ~have;
	assign fire  = ce_in & have & (~out_valid_out | out_ready_in);
	assign last  = ~enable_in | ph;
	// midpoint between previous and current sample, then the current one
	assign sum_i = {a_i[15], a_i} + {b_i[15], b_i};
	assign sum_q = {a_q[15], a_q} + {b_q[15], b_q};
	assign pre_i = last ? b_i : sum_i[16:1];
	assign pre_q = last ? b_q : sum_q[16:1];
	// mixing inside the stage, fractions of the output rate
	assign mixed = enable_in ? icm_pkg::icm_mix(pre_i, pre_q, idx, mode_in)
		: {pre_i, pre_q};

	// sample holding and phase, two outputs per input when enabled
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			have <= 1'b0;
			ph   <= 1'b0;
			a_i  <= '0;
			a_q  <= '0;
			b_i  <= '0;
			b_q  <= '0;
		end
		else if (load)
		begin
			a_i  <= b_i;
			a_q  <= b_q;
			b_i  <= in_i_in;
			b_q  <= in_q_in;
			have <= 1'b1;
			ph   <= 1'b0;
		end
		else if (fire)
		begin
			ph   <= 1'b1;
			have <= ~last;
		end
	end

	// sequence index steps once per output sample
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			idx <= 3'h0;
		else if (fire & enable_in)
			idx <= idx + 3'h1;
	end

	// registered output with back-pressure
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			out_valid_out <= 1'b0;
			out_i_out     <= '0;
			out_q_out     <= '0;
		end
		else if (fire)
		begin
			out_valid_out <= 1'b1;
			out_i_out     <= mixed[31:16];
			out_q_out     <= mixed[15:0];
		end
		else if (ce_in & out_ready_in)
			out_valid_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_mix(logic [2:0] md, logic [2:0] step, logic [2:0] msk);
		fire && enable_in && mode_in == md && (idx & msk) == step;
	endsequence

	property p_fs2;
		s_mix(icm_pkg::ICM_MIX_FS2, 3'h1, 3'h1) |=>
			out_i_out == icm_pkg::icm_neg($past(pre_i)) &&
			out_q_out == icm_pkg::icm_neg($past(pre_q));
	endproperty
	a_fs2: assert property (p_fs2) else $error("half-rate negation wrong");

	property p_fs4;
		s_mix(icm_pkg::ICM_MIX_FS4, 3'h1, 3'h3) |=>
			out_i_out == $past(pre_q) &&
			out_q_out == icm_pkg::icm_neg($past(pre_i));
	endproperty
	a_fs4: assert property (p_fs4) else $error("quarter-rate step wrong");

	property p_fs34;
		s_mix(icm_pkg::ICM_MIX_FS34, 3'h3, 3'h3) |=>
			out_i_out == $past(pre_q) &&
			out_q_out == icm_pkg::icm_neg($past(pre_i));
	endproperty
	a_fs34: assert property (p_fs34) else $error("3/4-rate step wrong");

	property p_fs8;
		s_mix(icm_pkg::ICM_MIX_FS8, 3'h2, 3'h7) |=>
			out_i_out == $past(pre_q) &&
			out_q_out == icm_pkg::icm_neg($past(pre_i));
	endproperty
	a_fs8: assert property (p_fs8) else $error("eighth-rate step wrong");

	property p_idx;
		fire && enable_in |=> idx == $past(idx) + 3'h1;
	endproperty
	a_idx: assert property (p_idx) else $error("mix index did not step");

	sequence s_first;
		fire && enable_in && !ph;
	endsequence
	property p_double;
		s_first |=> have && ph;
	endproperty
	a_double: assert property (p_double) else $error("second output lost");
endmodule
`default_nettype wire

// ---- hw/icm_top.sv ----
// interpolation datapath with coarse mixing, input packing and tuning word
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module icm_top (
	// clock, reset, enable
	input  wire logic               core_clk_in,
	input  wire logic               arst_n_in,
	input  wire logic               ce_in,
	// apb slave
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [7:0]         paddr_in,
	input  wire logic [31:0]        pwdata_in,
	output logic      [31:0]        prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	// parallel sample bus from the host
	input  wire logic [15:0]        smp_data_in,
	input  wire logic               smp_valid_in,
	output logic                    smp_ready_out,
	// samples toward the converter core
	output logic signed [15:0]      dac_i_out,
	output logic signed [15:0]      dac_q_out,
	output logic                    dac_valid_out,
	input  wire logic               dac_ready_in,
	// oscillator phase
	output logic      [31:0]        nco_phase_out
);
	localparam int NS = icm_pkg::ICM_STAGES;

	logic [31:0]        ctrl;
	logic [31:0]        mode;
	logic [31:0]        tune_shadow;
	logic [31:0]        carrier_tuning_word;
	logic               upd_bit;
	logic               upd_prev;
	logic [31:0]        shift;
	logic [2:0]         beat_cnt;
	logic               asm_valid;
	logic               pm_toggle;
	logic [1:0]         bw;
	logic [2:0]         last_beat;
	logic               beat;
	logic               pair_done;
	logic [2:0]         en_raw;
	logic [2:0]         en_eff;
	logic               cfg_err;
	logic               upd_rise;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               fifo_out_ready;
	logic [31:0]        fifo_out_data;
	logic signed [15:0] pm_i;
	logic signed [15:0] pm_q;
	logic               st_valid [NS+1];
	logic               st_ready [NS+1];
	logic signed [15:0] st_i     [NS+1];
	logic signed [15:0] st_q     [NS+1];
	logic               apb_setup;
	logic               apb_wr;
	logic               hit_ctrl;
	logic               hit_mode;
	logic               hit_tune;
	logic               hit_upd;
	logic               hit_any;
	logic [31:0]        rd_mux;

	////////////////////////////////////////////////////////////////////////
	// apb decode, one wait-free access phase while enabled
	assign apb_setup   = ce_in & psel_in & ~penable_in;
	assign apb_wr      = ce_in & psel_in & penable_in & pwrite_in;
	assign hit_ctrl    = (paddr_in == icm_pkg::ICM_OFF_CTRL);
	assign hit_mode    = (paddr_in == icm_pkg::ICM_OFF_MODE);
	assign hit_tune    = (paddr_in == icm_pkg::ICM_OFF_TUNE);
	assign hit_upd     = (paddr_in == icm_pkg::ICM_OFF_UPD);
	assign hit_any     = hit_ctrl | hit_mode | hit_tune | hit_upd
		| (paddr_in == icm_pkg::ICM_OFF_STAT)
		| (paddr_in == icm_pkg::ICM_OFF_ACTIVE)
		| (paddr_in == icm_pkg::ICM_OFF_PHASE);
	assign pready_out  = ce_in;
	assign pslverr_out = psel_in & penable_in & ~hit_any;

	// read selection
	assign rd_mux =
		hit_ctrl ? ctrl :
		hit_mode ? mode :
		hit_tune ? tune_shadow :
		hit_upd  ? {31'h0, upd_bit} :
		(paddr_in == icm_pkg::ICM_OFF_STAT) ?
			{28'h0, dac_valid_out, asm_valid, ~fifo_in_ready, cfg_err} :
		(paddr_in == icm_pkg::ICM_OFF_ACTIVE) ? carrier_tuning_word :
		(paddr_in == icm_pkg::ICM_OFF_PHASE) ? nco_phase_out : 32'h0;

	// read data captured in the setup cycle
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			prdata_out <= 32'h0;
		else if (apb_setup)
			prdata_out <= rd_mux;
	end

	// writable registers
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl        <= icm_pkg::ICM_CTRL_RST;
			mode        <= icm_pkg::ICM_MODE_RST;
			tune_shadow <= icm_pkg::ICM_TUNE_RST;
			upd_bit     <= 1'b0;
		end
		else if (apb_wr)
		begin
			if (hit_ctrl)
				ctrl <= pwdata_in;
			if (hit_mode)
				mode <= pwdata_in;
			if (hit_tune)
				tune_shadow <= pwdata_in;
			if (hit_upd)
				upd_bit <= pwdata_in[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// tuning word takes effect only on an update rising edge
	assign upd_rise = upd_bit & ~upd_prev;

	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			upd_prev            <= 1'b0;
			carrier_tuning_word <= icm_pkg::ICM_TUNE_RST;
			nco_phase_out       <= 32'h0;
		end
		else if (ce_in)
		begin
			upd_prev <= upd_bit;
			if (upd_rise)
				carrier_tuning_word <= tune_shadow;
			nco_phase_out <= nco_phase_out + carrier_tuning_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input packing: I first, most significant part first
	assign bw = ctrl[icm_pkg::ICM_CTRL_BW_LSB +: 2];
	assign last_beat = (bw == icm_pkg::ICM_BW_NIBBLE) ? icm_pkg::ICM_LAST_NIBBLE :
		(bw == icm_pkg::ICM_BW_BYTE) ? icm_pkg::ICM_LAST_BYTE :
		icm_pkg::ICM_LAST_WORD;
	assign smp_ready_out = ~asm_valid;
	assign beat          = ce_in & smp_valid_in & ~asm_valid;
	assign pair_done     = beat & (beat_cnt == last_beat);

	// shift in one transfer per accepted beat
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			shift     <= 32'h0;
			beat_cnt  <= 3'h0;
			asm_valid <= 1'b0;
		end
		else if (beat)
		begin
			if (bw == icm_pkg::ICM_BW_NIBBLE)
				shift <= {shift[27:0], smp_data_in[3:0]};
			else if (bw == icm_pkg::ICM_BW_BYTE)
				shift <= {shift[23:0], smp_data_in[7:0]};
			else
				shift <= {shift[15:0], smp_data_in};
			beat_cnt  <= pair_done ? 3'h0 : beat_cnt + 3'h1;
			asm_valid <= pair_done;
		end
		else if (ce_in & asm_valid & fifo_in_ready)
			asm_valid <= 1'b0;
	end

	// pair buffer between the bus and the stages
	icm_fifo #(
		.WIDTH (icm_pkg::ICM_FIFO_WIDTH),
		.DEPTH (icm_pkg::ICM_FIFO_DEPTH)
	) u_fifo (
		.clk_in       (core_clk_in),
		.arst_n_in    (arst_n_in),
		.ce_in        (ce_in),
		.wr_valid_in  (asm_valid),
		.wr_ready_out (fifo_in_ready),
		.wr_data_in   (shift),
		.rd_valid_out (fifo_out_valid),
		.rd_ready_in  (fifo_out_ready),
		.rd_data_out  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////
	// optional premodulation: half input rate shift, host selects it
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pm_toggle <= 1'b0;
		else if (ce_in & fifo_out_valid & fifo_out_ready)
			pm_toggle <= ~pm_toggle;
	end

	assign pm_i = (ctrl[icm_pkg::ICM_CTRL_PM_BIT] & pm_toggle) ?
		icm_pkg::icm_neg(fifo_out_data[31:16]) : fifo_out_data[31:16];
	assign pm_q = (ctrl[icm_pkg::ICM_CTRL_PM_BIT] & pm_toggle) ?
		icm_pkg::icm_neg(fifo_out_data[15:0]) : fifo_out_data[15:0];

	////////////////////////////////////////////////////////////////////////
	// stage enables: third only behind second, so 3-alone and 1+3 fall back
	assign en_raw = ctrl[icm_pkg::ICM_CTRL_EN_LSB +: 3];
	assign en_eff = {en_raw[2] & en_raw[1], en_raw[1:0]};
	assign cfg_err = en_raw[2] & ~en_raw[1];

	assign st_valid[0]    = fifo_out_valid;
	assign fifo_out_ready = st_ready[0];
	assign st_i[0]        = pm_i;
	assign st_q[0]        = pm_q;

	// chain of three stages, each with its own mix mode
	for (genvar k = 0; k < NS; k++)
	begin : g_stage
		icm_hb_stage u_stage (
			.clk_in        (core_clk_in),
			.arst_n_in     (arst_n_in),
			.ce_in         (ce_in),
			.enable_in     (en_eff[k]),
			.mode_in       (mode[k*icm_pkg::ICM_MODE_STRIDE +: 3]),
			.in_valid_in   (st_valid[k]),
			.in_ready_out  (st_ready[k]),
			.in_i_in       (st_i[k]),
			.in_q_in       (st_q[k]),
			.out_valid_out (st_valid[k+1]),
			.out_ready_in  (st_ready[k+1]),
			.out_i_out     (st_i[k+1]),
			.out_q_out     (st_q[k+1])
		);
	end

	// converter side, straight from the last stage registers
	assign st_ready[NS]  = dac_ready_in;
	assign dac_valid_out = st_valid[NS];
	assign dac_i_out     = st_i[NS];
	assign dac_q_out     = st_q[NS];

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	property p_tune_hold;
		ce_in && !upd_rise |=> carrier_tuning_word == $past(carrier_tuning_word);
	endproperty
	a_tune_hold: assert property (p_tune_hold) else $error("tuning word moved");

	property p_tune_load;
		ce_in && upd_rise |=> carrier_tuning_word == $past(tune_shadow);
	endproperty
	a_tune_load: assert property (p_tune_load) else $error("tuning word not loaded");

	property p_phase;
		ce_in |=> nco_phase_out == $past(nco_phase_out) + $past(carrier_tuning_word);
	endproperty
	a_phase: assert property (p_phase) else $error("phase step wrong");

	sequence s_nibble_pair;
		beat && bw == icm_pkg::ICM_BW_NIBBLE && beat_cnt == 3'h7;
	endsequence
	property p_pair;
		s_nibble_pair |=> asm_valid && beat_cnt == 3'h0;
	endproperty
	a_pair: assert property (p_pair) else $error("nibble pair not formed");

	property p_cfg;
		en_eff[2] |-> en_eff[1];
	endproperty
	a_cfg: assert property (p_cfg) else $error("third stage without second");
endmodule
`default_nettype wire

// ---- test/icm_host.sv ----
// host model that sends i/q pairs as beats on the sample bus
`timescale 1ns/100ps
`default_nettype none
module icm_host (
	// clock
	input  wire logic        clk_in,
	// sample bus
	input  wire logic        ready_in,
	output logic      [15:0] data_out,
	output logic             valid_out
);
	int tmo = 0;
	initial
	begin
		data_out = 16'h0000;
		valid_out = 1'b0;
	end
	// one complex pair, i then q, msb part first
	task automatic send(input logic [31:0] pair, input logic [1:0] bw);
		int n;
		int t;
		n = (bw == 2'h0) ? 8 : (bw == 2'h1) ? 4 : 2;
		for (int b = 0; b < n; b++)
		begin
			valid_out <= 1'b1;
			data_out <= 16'((pair << (b * 32 / n)) >> (32 - 32 / n));
			// beat held until ready is seen high at a rising edge
			t = 0;
			do
			begin
				@(posedge clk_in);
				t++;
			end
			while (ready_in !== 1'b1 && t < 1000);
			if (ready_in !== 1'b1)
				tmo++;
		end
		// released bus shows the inverse of the last beat
		valid_out <= 1'b0;
		data_out <= ~data_out;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ---- test/tb_interpolation_coarse_modulator.sv ----
// self-checking bench for the interpolation datapath
`timescale 1ns/100ps
`default_nettype none
module tb_interpolation_coarse_modulator;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] sdata;
	logic        svalid;
	logic        sready;
	logic [15:0] di;
	logic [15:0] dq;
	logic        dvalid;
	logic        ce = 1'b1;
	logic        dready = 1'b0;
	logic        stall = 1'b0;
	logic [31:0] nco;
	logic [31:0] rv;
	logic        re;
	logic [31:0] got[$];
	int          err_total = 0;
	int          checks_done = 0;
	// operand index tables of the mixing sequences, step 0 leftmost
	localparam logic [31:0] SEQ_I [5] = '{32'h00000000, 32'h02020202,
		32'h01230123, 32'h03210321, 32'h04152637};
	localparam logic [31:0] SEQ_Q [5] = '{32'h11111111, 32'h13131313,
		32'h12301230, 32'h10321032, 32'h15263704};

	icm_top i_icm_top (.core_clk_in(clk), .arst_n_in(arst_n), .ce_in(ce),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .smp_data_in(sdata),
		.smp_valid_in(svalid), .smp_ready_out(sready), .dac_i_out(di),
		.dac_q_out(dq), .dac_valid_out(dvalid), .dac_ready_in(dready),
		.nco_phase_out(nco));
	icm_host i_icm_host (.clk_in(clk), .ready_in(sready), .data_out(sdata),
		.valid_out(svalid));

	// clock, collector and randomly stalling sink
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		if (dvalid && dready)
			got.push_back({di, dq});
		dready <= !stall && ($urandom % 4 != 0);
	end

	////////////////////////////////////////////////////////////////////////
	function automatic int sat(int v);
		return v > 32767 ? 32767 : v < -32768 ? -32768 : v;
	endfunction
	// reference mixing step k of mode md, returns {i, q}
	function automatic logic [31:0] mix(int i, int q, int k, int md);
		int p;
		int m;
		int v[8];
		p = sat(((i + q) * 23170) >>> 15);
		m = sat(((q - i) * 23170) >>> 15);
		v = '{i, q, sat(-i), sat(-q), p, m, sat(-p), sat(-m)};
		return {16'(v[SEQ_I[md][(7 - k % 8) * 4 +: 3]]),
			16'(v[SEQ_Q[md][(7 - k % 8) * 4 +: 3]])};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int t;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// access phase held until pready is seen high at a rising edge
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (pready !== 1'b1 && t < 100);
		if (pready !== 1'b1)
		begin
			err_total++;
			test_done();
		end
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_got(int n);
		int t;
		t = 0;
		while (got.size() < n && t < 3000)
		begin
			@(posedge clk);
			t++;
		end
		if (got.size() < n)
		begin
			err_total++;
			test_done();
		end
	endtask
	task automatic rst();
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		got.delete();
	endtask
	task automatic test_done();
		err_total += i_icm_host.tmo;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int i;
		int q;
		logic [31:0] x;
		logic [31:0] y;
		x = $urandom(32'h2e19);
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// reset values, unmapped place, tuning word update
		apb(1'b0, icm_pkg::ICM_OFF_CTRL, 32'h0);
		chk(rv, icm_pkg::ICM_CTRL_RST);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, re}, 32'h1);
		x = $urandom;
		apb(1'b1, icm_pkg::ICM_OFF_TUNE, x);
		apb(1'b0, icm_pkg::ICM_OFF_ACTIVE, 32'h0);
		chk(rv, 32'h0);
		apb(1'b1, icm_pkg::ICM_OFF_UPD, 32'h0);
		apb(1'b1, icm_pkg::ICM_OFF_UPD, 32'h1);
		apb(1'b0, icm_pkg::ICM_OFF_ACTIVE, 32'h0);
		chk(rv, x);
		// phase steps by the active word, frozen while disabled
		@(posedge clk);
		y = nco;
		@(posedge clk);
		chk(nco - y, x);
		ce <= 1'b0;
		@(posedge clk);
		y = nco;
		@(posedge clk);
		chk(nco, y);
		ce <= 1'b1;
		// bus widths through a bypassed path, premodulation on odd pairs
		for (int bw = 0; bw < 3; bw++)
		begin
			rst();
			apb(1'b1, icm_pkg::ICM_OFF_CTRL, 32'(bw) | 32'h20);
			x = $urandom;
			repeat (2) i_icm_host.send(x, 2'(bw));
			wait_got(2);
			chk(got[0], x);
			i = $signed(x[31:16]);
			q = $signed(x[15:0]);
			chk(got[1], mix(i, q, 1, 1));
		end
		// modes fs2, fs4, fs34 and fs8 on first and second stage alone, twice the outputs
		for (int st = 0; st < 2; st++)
			for (int md = 1; md < 5; md++)
				for (int vec = 0; vec < 2; vec++)
				begin
					rst();
					apb(1'b1, icm_pkg::ICM_OFF_CTRL, 32'h2 | (32'h4 << st));
					apb(1'b1, icm_pkg::ICM_OFF_MODE, 32'(md) << (st * 4));
					i = vec ? -32768 : sat($signed(16'($urandom)));
					q = vec ? 32767 : sat($signed(16'($urandom)));
					repeat (5) i_icm_host.send({16'(i), 16'(q)}, 2'h2);
					wait_got(10);
					chk(got[0], mix(i >>> 1, q >>> 1, 0, md));
					for (int k = 1; k < 10; k++)
						chk(got[k], mix(i, q, k, md));
				end
		// fill the buffer with the sink stalled, then drain in order
		rst();
		stall = 1'b1;
		fork
			for (int n = 0; n < 12; n++)
				i_icm_host.send(32'h01000100 * n, 2'h2);
		join_none
		repeat (200) @(posedge clk);
		apb(1'b0, icm_pkg::ICM_OFF_STAT, 32'h0);
		chk(rv & 32'h6, 32'h6);
		stall = 1'b0;
		wait_got(12);
		for (int n = 0; n < 12; n++)
			chk(got[n], 32'h01000100 * n);
		test_done();
	end
endmodule
`default_nettype wire
